// file: hw/flash_command_sequencer.sv
// flash command sequencer: unlock decoder, program/erase timing, toggle polling, array
// How it works
// - two unlock writes start every command but the F0 id exit
// - third write picks program, id, security
// - erase setup, unlock, then sector or chip
// - data F0 anywhere leaves id mode
// - fourth write gives program address, data
// - area select windows program addresses
// - sixth address top nibble picks sector
// - program ends within 40 us, busy
// - sector erase ends within 30 ms
// - bit six flips per read while busy
// - erased bytes read all ones
// - no sector erase in parallel mode
// - first poll reads one, frozen disabled
`timescale 1ns/100ps
`default_nettype none

module flash_command_sequencer
	import flash_seq_pkg::*;
#(
	parameter int unsigned   ERASE_CYCLES_P  = ERASE_CYCLES,  // shortened in simulation
	parameter logic [7:0]    ID_VENDOR_CODE  = 8'h5A,         // arbitrary value
	parameter logic [7:0]    ID_DEVICE_CODE  = 8'h3C          // arbitrary value
) (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_resetn,
	// cpu access to the flash space
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// committed control settings
	input  wire logic [1:0]  i_area_select,
	input  wire logic        i_cmd_enable,
	input  wire logic        i_parallel_prom,
	// status
	output logic             o_busy,
	output logic             o_id_mode,
	output logic             o_secured
);

	// timer loads, cut to the timer width once here
	localparam logic [TIMER_BITS-1:0] PROG_LOAD  = TIMER_BITS'(PROGRAM_CYCLES - 1);
	localparam logic [TIMER_BITS-1:0] ERASE_LOAD = TIMER_BITS'(ERASE_CYCLES_P - 1);

	seq_t        q;                     // registered state
	seq_t        next_q;                // next state
	logic [7:0]  mem [0:ARRAY_BYTES-1]; // flash cells, not reset like real flash
	logic        mem_we;                // array write this cycle
	logic [15:0] mem_addr;              // array write address
	logic [7:0]  mem_wdata;             // array write byte
	logic        first_ofs;             // write hits the first unlock offset
	logic        second_ofs;            // write hits the second unlock offset
	logic        windowed;              // area select maps low area through high addresses
	logic        in_range;              // target inside the window of this area select
	logic [15:0] phys;                  // physical cell address of a target
	logic [7:0]  rd_byte;               // byte returned for a read

	// address helpers shared by the decoder
	always_comb begin
		first_ofs  = (i_addr[15:12] != NIBBLE_NONE) && (i_addr[11:0] == OFS_FIRST);
		second_ofs = (i_addr[15:12] != NIBBLE_NONE) && (i_addr[11:0] == OFS_SECOND);
		windowed   = i_area_select[AREA_WINDOW_BIT];
		in_range   = windowed ? (i_addr >= WINDOW_BASE) : (i_addr >= DIRECT_BASE);
		phys       = windowed ? (i_addr - ALIAS_OFFSET) : i_addr;
	end

	// next state: reads, busy timing and the command decoder
	always_comb begin
		next_q       = q;
		next_q.rdata = IDLE_READ;         // read data stands one cycle only
		mem_we       = 1'b0;
		mem_addr     = phys;
		mem_wdata    = i_wdata;
		rd_byte      = mem[i_addr];

		// read path
		if (i_rd) begin
			if (q.busy) begin
				rd_byte[TOGGLE_BIT] = q.toggle;
				if (i_cmd_enable) begin
					next_q.toggle = ~q.toggle;
				end
			end else if (q.id_mode) begin
				// identification view replaces a few addresses
				if (i_addr == ID_VENDOR_ADDR) begin
					rd_byte = ID_VENDOR_CODE;
				end else if (i_addr == ID_DEVICE_ADDR) begin
					rd_byte = ID_DEVICE_CODE;
				end else if (i_addr == SECURITY_ADDR) begin
					rd_byte = q.secured ? SECURITY_ON_READ : SECURITY_OFF_READ;
				end
			end
			next_q.rdata = rd_byte;
		end

		unique case (q.state)
			ST_BUSY: begin
				// writes ignored while busy; the cpu can only poll
				if (q.walking) begin
					// erased cells become all ones, one byte per cycle
					mem_we    = 1'b1;
					mem_addr  = q.walk;
					mem_wdata = ERASED_BYTE;
					if (q.walk == q.walk_last) begin
						next_q.walking = 1'b0;
					end else begin
						next_q.walk = q.walk + 16'h0001;
					end
				end
				if (q.timer != '0) begin
					next_q.timer = q.timer - 1'b1;
				end
				// done when timer and walk both end
				if ((q.timer == '0) && !q.walking) begin
					next_q.state = ST_IDLE;
					next_q.busy  = 1'b0;
				end
			end
			ST_IDLE: begin
				if (i_wr) begin
					if (i_wdata == CMD_ID_EXIT) begin
						next_q.id_mode = 1'b0;
					end else if (i_cmd_enable && first_ofs && i_wdata == UNLOCK_FIRST_DATA) begin
						next_q.state = ST_UNLOCK1;
					end
				end
			end
			ST_UNLOCK1: begin
				if (i_wr) begin
					next_q.state = ST_IDLE;
					if (i_cmd_enable && second_ofs && i_wdata == UNLOCK_SECOND_DATA) begin
						next_q.state = ST_UNLOCK2;
					end else if (i_wdata == CMD_ID_EXIT) begin
						next_q.id_mode = 1'b0;
					end
				end
			end
			ST_UNLOCK2: begin
				if (i_wr) begin
					next_q.state = ST_IDLE;
					if (i_wdata == CMD_ID_EXIT) begin
						next_q.id_mode = 1'b0;
					end else if (i_cmd_enable && first_ofs) begin
						if (i_wdata == CMD_BYTE_PROGRAM) begin
							next_q.state = ST_PROGRAM;
						end else if (i_wdata == CMD_ID_ENTRY) begin
							next_q.id_mode = 1'b1;
						end else if (i_wdata == CMD_SECURITY) begin
							next_q.state = ST_SECURITY;
						end else if (i_wdata == CMD_ERASE_SETUP) begin
							next_q.state = ST_ERASE3;
						end
					end
				end
			end
			ST_PROGRAM: begin
				if (i_wr) begin
					next_q.state = ST_IDLE;
					if (i_wdata == CMD_ID_EXIT) begin
						next_q.id_mode = 1'b0;
					end else if (i_cmd_enable && in_range) begin
						mem_we        = 1'b1;
						next_q.state  = ST_BUSY;
						next_q.busy   = 1'b1;
						next_q.toggle = 1'b1;
						next_q.timer  = PROG_LOAD;
					end
				end
			end
			ST_SECURITY: begin
				if (i_wr) begin
					next_q.state = ST_IDLE;
					if (i_cmd_enable && i_addr == SECURITY_ADDR && i_wdata == SECURITY_DATA) begin
						next_q.secured = 1'b1;
						next_q.state   = ST_BUSY;
						next_q.busy    = 1'b1;
						next_q.toggle  = 1'b1;
						next_q.timer   = PROG_LOAD;
					end else if (i_wdata == CMD_ID_EXIT) begin
						next_q.id_mode = 1'b0;
					end
				end
			end
			ST_ERASE3: begin
				if (i_wr) begin
					next_q.state = ST_IDLE;
					if (i_cmd_enable && first_ofs && i_wdata == UNLOCK_FIRST_DATA) begin
						next_q.state = ST_ERASE4;
					end else if (i_wdata == CMD_ID_EXIT) begin
						next_q.id_mode = 1'b0;
					end
				end
			end
			ST_ERASE4: begin
				if (i_wr) begin
					next_q.state = ST_IDLE;
					if (i_cmd_enable && second_ofs && i_wdata == UNLOCK_SECOND_DATA) begin
						next_q.state = ST_ERASE5;
					end else if (i_wdata == CMD_ID_EXIT) begin
						next_q.id_mode = 1'b0;
					end
				end
			end
			ST_ERASE5: begin
				if (i_wr) begin
					next_q.state = ST_IDLE;
					if (i_wdata == CMD_ID_EXIT) begin
						next_q.id_mode = 1'b0;
					end else if (!i_cmd_enable) begin
						next_q.state = ST_IDLE;
					end else if (i_wdata == CMD_SECTOR_ERASE && in_range && !i_parallel_prom) begin
						next_q.walk      = {phys[15:12], SECTOR_FIRST_OFS};
						next_q.walk_last = {phys[15:12], SECTOR_LAST_OFS};
						next_q.walking   = 1'b1;
						next_q.state     = ST_BUSY;
						next_q.busy      = 1'b1;
						next_q.toggle    = 1'b1;
						next_q.timer     = ERASE_LOAD;
					end else if (i_wdata == CMD_CHIP_ERASE && first_ofs) begin
						// chip erase also lifts the security setting
						next_q.walk      = ARRAY_FIRST;
						next_q.walk_last = ARRAY_LAST;
						next_q.walking   = 1'b1;
						next_q.secured   = 1'b0;
						next_q.state     = ST_BUSY;
						next_q.busy      = 1'b1;
						next_q.toggle    = 1'b1;
						next_q.timer     = ERASE_LOAD;
					end
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			q <= SEQ_RESET;
		end else begin
			q <= next_q;
		end
	end

	// array write port; a reset mid-operation leaves cells as they stand
	always_ff @(posedge i_ref_clk) begin
		if (mem_we) begin
			mem[mem_addr] <= mem_wdata;
		end
	end

	// outputs straight from the state register
	assign o_rdata   = q.rdata;
	assign o_busy    = q.busy;
	assign o_id_mode = q.id_mode;
	assign o_secured = q.secured;

endmodule : flash_command_sequencer

`default_nettype wire

// file: hw/flash_seq_pkg.sv
// constants, state codes and state record for the flash command sequencer
package flash_seq_pkg;

	// unlock pattern and command codes
	localparam logic [7:0]  UNLOCK_FIRST_DATA  = 8'hAA;
	localparam logic [7:0]  UNLOCK_SECOND_DATA = 8'h55;
	localparam logic [7:0]  CMD_BYTE_PROGRAM   = 8'hA0;
	localparam logic [7:0]  CMD_ID_ENTRY       = 8'h90;
	localparam logic [7:0]  CMD_SECURITY       = 8'hA5;
	localparam logic [7:0]  CMD_ERASE_SETUP    = 8'h80;
	localparam logic [7:0]  CMD_SECTOR_ERASE   = 8'h30;
	localparam logic [7:0]  CMD_CHIP_ERASE     = 8'h10;
	localparam logic [7:0]  CMD_ID_EXIT        = 8'hF0;
	localparam logic [7:0]  SECURITY_DATA      = 8'h00;

	// address offsets and windows
	localparam logic [11:0] OFS_FIRST          = 12'h555;
	localparam logic [11:0] OFS_SECOND         = 12'hAAA;
	localparam logic [11:0] SECTOR_FIRST_OFS   = 12'h000;
	localparam logic [11:0] SECTOR_LAST_OFS    = 12'hFFF;
	localparam logic [3:0]  NIBBLE_NONE        = 4'h0;
	localparam logic [15:0] SECURITY_ADDR      = 16'hFF7F;
	localparam logic [15:0] WINDOW_BASE        = 16'h9000;
	localparam logic [15:0] DIRECT_BASE        = 16'h8000;
	localparam logic [15:0] ALIAS_OFFSET       = 16'h8000;
	localparam logic [15:0] ARRAY_FIRST        = 16'h1000;
	localparam logic [15:0] ARRAY_LAST         = 16'hFFFF;
	localparam logic [15:0] ID_VENDOR_ADDR     = 16'hF000;
	localparam logic [15:0] ID_DEVICE_ADDR     = 16'hF001;
	localparam int          ARRAY_BYTES        = 65536;

	// read values
	localparam logic [7:0]  ERASED_BYTE        = 8'hFF;
	localparam logic [7:0]  SECURITY_OFF_READ  = 8'hFF;
	localparam logic [7:0]  SECURITY_ON_READ   = 8'h00;
	localparam logic [7:0]  IDLE_READ          = 8'h00;
	localparam int          TOGGLE_BIT         = 6;
	localparam int          AREA_WINDOW_BIT    = 0;

	// timing: longest times rounded down to whole cycles
	localparam int          CLK_MHZ            = 50;
	localparam int          PROGRAM_TIME_US    = 40;
	localparam int          ERASE_TIME_MS      = 30;
	localparam int          PROGRAM_CYCLES     = PROGRAM_TIME_US * CLK_MHZ;
	localparam int          ERASE_CYCLES       = ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam int          TIMER_BITS         = 21;

	// decoder states, one-hot
	typedef enum logic [8:0] {
		ST_IDLE     = 9'b0_0000_0001,
		ST_UNLOCK1  = 9'b0_0000_0010,
		ST_UNLOCK2  = 9'b0_0000_0100,
		ST_PROGRAM  = 9'b0_0000_1000,
		ST_SECURITY = 9'b0_0001_0000,
		ST_ERASE3   = 9'b0_0010_0000,
		ST_ERASE4   = 9'b0_0100_0000,
		ST_ERASE5   = 9'b0_1000_0000,
		ST_BUSY     = 9'b1_0000_0000
	} seq_state_t;

	// whole state of the sequencer
	typedef struct packed {
		seq_state_t              state;
		logic [TIMER_BITS-1:0]   timer;
		logic [15:0]             walk;
		logic [15:0]             walk_last;
		logic                    walking;
		logic                    toggle;
		logic                    busy;
		logic                    id_mode;
		logic                    secured;
		logic [7:0]              rdata;
	} seq_t;

	localparam seq_t SEQ_RESET = '{state: ST_IDLE, default: '0};

endpackage : flash_seq_pkg

// file: tb/flash_command_sequencer_tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_command_sequencer_tb;
	localparam logic [7:0] VEND = 8'hC3; // arbitrary value
	localparam logic [7:0] DEVC = 8'h6E; // arbitrary value
	logic             clk    = 1'b0; // 50 MHz reference
	logic             resetn = 1'b0; // chip reset
	wire logic [15:0] addr;
	wire logic [7:0]  wd;
	wire logic [7:0]  rdata;
	wire logic [1:0]  area;
	wire logic        wr, rd, en, par, busy, idm, sec;
	int               errors     = 0;
	int               num_checks = 0;
	logic [7:0]       x;
	always #10 clk = ~clk;
	flash_cpu_model cpu (.i_ref_clk(clk), .o_addr(addr), .o_wdata(wd), .o_wr(wr), .o_rd(rd),
		.i_rdata(rdata), .o_area(area), .o_en(en), .o_par(par));
	// short erase timer keeps the run brief
	flash_command_sequencer #(.ERASE_CYCLES_P(5000), .ID_VENDOR_CODE(VEND),
		.ID_DEVICE_CODE(DEVC)) i_flash_command_sequencer (.i_ref_clk(clk), .i_resetn(resetn),
		.i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_area_select(area), .i_cmd_enable(en), .i_parallel_prom(par), .o_busy(busy),
		.o_id_mode(idm), .o_secured(sec));
	// compare and count
	task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	// read one byte and compare
	task automatic rc(input string nm, input logic [15:0] a, input logic [7:0] e);
		cpu.rd(a, x);
		check(nm, x, e);
	endtask : rc
	// chip erase first: the array holds no known value after reset
	task automatic t_chip();
		cpu.setup(2'b10, 1'b0);
		cpu.erase(16'hF555, 8'h10);
		#1 check("chip busy", 8'(busy), 8'h01);
		cpu.poll(16'h8000);
		rc("low", 16'h1000, 8'hFF);
		rc("high", 16'hFFFF, 8'hFF);
	endtask : t_chip
	// program with polling; a command while busy must be dropped
	task automatic t_prog();
		cpu.setup(2'b00, 1'b0);
		cpu.cmd(8'hA0);
		cpu.wr(16'h8123, 8'h3C);
		rc("first poll", 16'h8123, 8'h7C);
		rc("second poll", 16'h8123, 8'h3C);
		cpu.cmd(8'hA0);
		cpu.wr(16'h8200, 8'h00);
		cpu.poll(16'h8123);
		rc("programmed", 16'h8123, 8'h3C);
		rc("refused", 16'h8200, 8'hFF);
	endtask : t_prog
	// window mapping, and a target outside it is abandoned
	task automatic t_win();
		cpu.setup(2'b11, 1'b0);
		cpu.cmd(8'hA0);
		cpu.wr(16'h8500, 8'h00);
		#1 check("outside", 8'(busy), 8'h00);
		cpu.cmd(8'hA0);
		cpu.wr(16'h9010, 8'h81);
		cpu.poll(16'h1010);
		rc("window", 16'h1010, 8'h81);
		rc("direct", 16'h9010, 8'hFF);
	endtask : t_win
	// sector erase refused in parallel mode, then done for real
	task automatic t_sect();
		cpu.setup(2'b01, 1'b1);
		cpu.erase(16'h9ABC, 8'h30);
		#1 check("parallel", 8'(busy), 8'h00);
		rc("kept", 16'h1010, 8'h81);
		cpu.setup(2'b01, 1'b0);
		cpu.erase(16'h9ABC, 8'h30);
		#1 check("erasing", 8'(busy), 8'h01);
		cpu.poll(16'h1010);
		rc("sector", 16'h1010, 8'hFF);
		rc("other", 16'h8123, 8'h3C);
	endtask : t_sect
	// identification, security, and broken sequences
	task automatic t_id();
		cpu.setup(2'b00, 1'b0);
		cpu.cmd(8'h90);
		#1 check("id on", 8'(idm), 8'h01);
		rc("vendor", 16'hF000, VEND);
		rc("device", 16'hF001, DEVC);
		rc("open", 16'hFF7F, 8'hFF);
		cpu.wr(16'h1234, 8'hF0);
		#1 check("id off", 8'(idm), 8'h00);
		rc("normal", 16'hF000, 8'hFF);
		cpu.cmd(8'hA5);
		cpu.wr(16'hFF7F, 8'h00);
		#1 check("secured", 8'(sec), 8'h01);
		cpu.poll(16'h8000);
		cpu.cmd(8'h77);
		#1 check("stray", 8'(busy | idm), 8'h00);
		cpu.wr(16'hF555, 8'hAA);
		cpu.wr(16'hF555, 8'hA0);
		cpu.wr(16'h8300, 8'h00);
		rc("untouched", 16'h8300, 8'hFF);
	endtask : t_id
	// counts, verdict, stop
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	// main sequence after a 16-cycle reset
	initial begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		t_chip();
		t_prog();
		t_win();
		t_sect();
		t_id();
		end_of_test();
	end
	// watchdog: chip erase walk dominates the expected run
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		end_of_test();
	end
endmodule : flash_command_sequencer_tb
`default_nettype wire

// file: tb/flash_cpu_model.sv
// cpu core model: bus cycles, command sequences, completion polling
`timescale 1ns/100ps
`default_nettype none
module flash_cpu_model (
	// clock
	input  wire logic        i_ref_clk,
	// bus to the sequencer
	output logic      [15:0] o_addr,
	output logic      [7:0]  o_wdata,
	output logic             o_wr,
	output logic             o_rd,
	input  wire logic [7:0]  i_rdata,
	// committed control levels
	output logic      [1:0]  o_area,
	output logic             o_en,
	output logic             o_par
);
	// quiet bus at time zero
	initial begin
		{o_addr, o_wdata, o_wr, o_rd, o_area, o_en, o_par} = '0;
	end
	// one write; lines go inverse after so a stale value never passes
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_ref_clk);
		o_wr    <= 1'b0;
		o_addr  <= ~a;
		o_wdata <= ~d;
	endtask : wr
	// one read; data stands only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_ref_clk);
		o_rd   <= 1'b0;
		o_addr <= ~a;
		#1 d = i_rdata;
	endtask : rd
	// commit area select and enable before any command
	task automatic setup(input logic [1:0] ar, input logic p);
		@(posedge i_ref_clk);
		o_area <= ar;
		o_en   <= 1'b1;
		o_par  <= p;
	endtask : setup
	// erased cells, one view, inside windows
	// model has no low power modes
	// unlock pair on nibble F, then the command
	task automatic cmd(input logic [7:0] c);
		wr(16'hF555, 8'hAA);
		wr(16'hFAAA, 8'h55);
		wr(16'hF555, c);
	endtask : cmd
	// erase setup, second unlock pair, then code at its address
	task automatic erase(input logic [15:0] a, input logic [7:0] c);
		cmd(8'h80);
		wr(16'hF555, 8'hAA);
		wr(16'hFAAA, 8'h55);
		wr(a, c);
	endtask : erase
	// read one address twice until both agree, bounded
	task automatic poll(input logic [15:0] a);
		logic [7:0] x;
		logic [7:0] y;
		int         n;
		n = 0;
		do begin
			rd(a, x);
			rd(a, y);
			n++;
		end while (x !== y && n < 20000);
	endtask : poll
endmodule : flash_cpu_model
`default_nettype wire

// file: tb/flash_seq_assertions.sv
// port checker for the flash command sequencer
`timescale 1ns/100ps
`default_nettype none
module flash_seq_checker (
	// clock and reset
	input wire logic        i_ref_clk,
	input wire logic        i_resetn,
	// cpu bus
	input wire logic [15:0] i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [7:0]  o_rdata,
	// control levels
	input wire logic [1:0]  i_area_select,
	input wire logic        i_cmd_enable,
	input wire logic        i_parallel_prom,
	// status
	input wire logic        o_busy,
	input wire logic        o_id_mode,
	input wire logic        o_secured
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);
	// a write the decoder may take, and one at the first command offset
	wire logic ok  = i_wr && !o_busy && i_cmd_enable && i_addr[15:12] != 4'h0;
	wire logic at5 = ok && i_addr[11:0] == 12'h555;
	// target inside the committed area window
	wire logic win = i_addr >= (i_area_select[0] ? 16'h9000 : 16'h8000);
	logic [2:0] s;   // shadow step through the command table
	logic       fst; // next busy read is the first of its spell
	// shadow decoder; any stray or busy write drops back to start
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s   <= 3'd0;
			fst <= 1'b0;
		end else begin
			if ($rose(o_busy)) begin
				fst <= 1'b1;
			end else if (i_rd) begin
				fst <= 1'b0;
			end
			if (i_wr) begin
				if (s == 3'd2 && at5 && i_wdata == 8'hA0) begin
					s <= 3'd3;
				end else if (s == 3'd2 && at5 && i_wdata == 8'h80) begin
					s <= 3'd4;
				end else if (at5 && i_wdata == 8'hAA && (s == 3'd0 || s == 3'd4)) begin
					s <= (s == 3'd4) ? 3'd5 : 3'd1;
				end else if (ok && i_addr[11:0] == 12'hAAA && i_wdata == 8'h55
					&& (s == 3'd1 || s == 3'd5)) begin
					s <= s + 3'd1;
				end else begin
					s <= 3'd0;
				end
			end
		end
	end
	AST_TOGGLE: assert property (o_busy && i_cmd_enable && i_rd ##2 o_busy && i_rd
		|=> o_rdata[6] != $past(o_rdata[6], 2)) else $error("bit six did not flip");
	AST_FIRST: assert property (fst && o_busy && i_rd |=> o_rdata[6])
		else $error("first busy read lacks bit six");
	AST_ID_EXIT: assert property (!o_busy && i_wr && i_wdata == 8'hF0 |=> !o_id_mode)
		else $error("identification mode kept");
	AST_ID_ENTRY: assert property (s == 3'd2 && at5 && i_wdata == 8'h90 |=> o_id_mode)
		else $error("identification mode not entered");
	AST_PROG: assert property (s == 3'd3 && ok && win && i_wdata != 8'hF0 |=> o_busy)
		else $error("byte program did not start");
	AST_SECT: assert property (s == 3'd6 && ok && win && !i_parallel_prom && i_wdata == 8'h30
		|=> o_busy) else $error("sector erase did not start");
	AST_PARALLEL: assert property (s == 3'd6 && i_wr && i_parallel_prom && i_wdata == 8'h30
		|=> !o_busy) else $error("sector erase ran in parallel mode");
	AST_REFUSE: assert property (o_busy && i_wr |=> $stable(o_id_mode) && $stable(o_secured))
		else $error("write taken while busy");
endmodule : flash_seq_checker
bind flash_command_sequencer flash_seq_checker i_flash_seq_checker (
	.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_area_select(i_area_select),
	.i_cmd_enable(i_cmd_enable), .i_parallel_prom(i_parallel_prom), .o_busy(o_busy),
	.o_id_mode(o_id_mode), .o_secured(o_secured));
`default_nettype wire
